/* logic/dcfc_pkg.sv */
// Function
// - Fields: init, target, register, data, check
// - Init byte first, fixes frame length
// - Init bit 7: command one, response zero
// - Request kind codes; 100 and 101 reserved
// - Width bit: 8-bit or 16-bit address
// - Length code 0-6 bytes, 111 is eight
// - Response init carries reply length minus one
// - Act when target equals node or group
// - Request kind picks node or group compare
// - Broadcast frames carry no target byte
// - Short address implies zero high byte
// - Register 2 data: sample command, configuration
// - Write-only frames store data sequentially
// - Write-with-response frames return register contents
// - Two check bytes, low byte first
// - Bytes sent LSB first, CRC follows
// - Nonzero CRC over whole frame rejects it
// - Respond only after a received command
package dcfc_pkg;
	localparam logic [7:0] REG_SAMPLE_CMD = 8'h02;
	localparam logic [7:0] REG_CHAN_SEL = 8'h03;
	localparam logic [7:0] REG_OVERSAMPLE = 8'h07;
	localparam logic [7:0] REG_NODE_ID = 8'h0a;
	localparam logic [7:0] REG_GROUP_MATCH_IDENTIFIER = 8'h0b;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [2:0] LEN_CODE_EIGHT = 3'h7;
	localparam logic [3:0] LEN_EIGHT = 4'h8;
	localparam logic [1:0] KIND_SINGLE = 2'h0;
	localparam logic [1:0] KIND_GROUP = 2'h1;
	localparam logic [1:0] KIND_RESERVED = 2'h2;
	localparam logic [1:0] KIND_BCAST = 2'h3;
	localparam logic [7:0] NODE_ID_RESET = 8'h00;
	localparam logic [7:0] GROUP_MATCH_IDENTIFIER_RESET = 8'h00;

	// Command initialization byte layout
	typedef struct packed {
		logic frame_kind_bit;
		logic [1:0] target_kind;
		logic no_reply;
		logic wide_addr;
		logic [2:0] len_code;
	} dcfc_cmd_init_t;

	// Response initialization byte layout
	typedef struct packed {
		logic frame_kind_bit;
		logic [6:0] reply_len_minus_one;
	} dcfc_resp_init_t;

	// Sampling configuration handed to the converter side
	typedef struct packed {
		logic [7:0] sample_cmd;
		logic [7:0] highest_node;
		logic [31:0] chan_select;
		logic [7:0] oversample;
	} dcfc_sample_cfg_t;
endpackage

/* logic/dcfc_codec.sv */
`timescale 1ns/1ps
`default_nettype none
module dcfc_codec #(
	parameter int NREG = 16,
	parameter logic [7:0] NODE_ID_INIT = dcfc_pkg::NODE_ID_RESET,
	parameter logic [7:0] GROUP_MATCH_IDENTIFIER_INIT = dcfc_pkg::GROUP_MATCH_IDENTIFIER_RESET
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_valid_i,
	output logic [7:0] tx_byte_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output dcfc_pkg::dcfc_sample_cfg_t sample_cfg_o,
	output logic sample_start_o,
	output logic frame_ok_o,
	output logic crc_err_o,
	output logic [7:0] node_id_o,
	output logic [7:0] group_match_identifier_o
);
	localparam int AW = $clog2(NREG);

	typedef enum logic [2:0] {
		R_INIT, R_ID, R_REGHI, R_REGLO, R_DATA, R_CRC1, R_CRC2, R_SKIP
	} dcfc_rx_state_t;
	typedef enum logic [2:0] {
		T_IDLE, T_INIT, T_DATA, T_CRC1, T_CRC2
	} dcfc_tx_state_t;

	// Reflected CRC over one byte, bits taken LSB first
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int k = 0; k < 8; k++) begin
			if (r[0] ^ d[k]) begin
				r = (r >> 1) ^ dcfc_pkg::CRC_POLY;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction

	dcfc_rx_state_t rx_state;
	dcfc_tx_state_t tx_state;
	dcfc_pkg::dcfc_cmd_init_t hdr;
	logic [7:0] target_id;
	logic [15:0] reg_addr;
	logic [7:0] data_buf [8];
	logic [3:0] data_idx;
	logic [3:0] data_len;
	logic [7:0] skip_cnt;
	logic [15:0] rx_crc;
	logic [15:0] next_rx_crc;
	logic [7:0] mem [NREG];
	logic frame_done;
	logic frame_good;
	logic target_hit;
	logic accept;
	logic is_sample;
	logic wr_busy;
	logic [3:0] wr_idx;
	logic [15:0] wr_addr;
	logic [15:0] rd_base;
	logic [6:0] rd_last;
	logic [6:0] rd_idx;
	logic [15:0] rd_addr;
	logic [7:0] rd_byte;
	logic [15:0] tx_crc;
	logic [15:0] next_tx_crc;
	logic [7:0] highest_node;

	// Length of the data field from the init byte
	function automatic logic [3:0] len_of(input logic [2:0] code);
		return (code == dcfc_pkg::LEN_CODE_EIGHT) ?
			dcfc_pkg::LEN_EIGHT : {1'b0, code};
	endfunction

	assign next_rx_crc = crc_byte((rx_state == R_INIT) ?
		dcfc_pkg::CRC_INIT : rx_crc, rx_byte_i);

	// Byte-by-byte frame parser
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_state <= R_INIT;
			hdr <= '0;
			target_id <= 8'h00;
			reg_addr <= 16'h0000;
			data_idx <= 4'h0;
			data_len <= 4'h0;
			skip_cnt <= 8'h00;
		end else if (rx_valid_i) begin
			unique case (rx_state)
				R_INIT: begin
					hdr <= dcfc_pkg::dcfc_cmd_init_t'(rx_byte_i);
					reg_addr <= 16'h0000;
					data_len <= len_of(rx_byte_i[2:0]);
					if (!rx_byte_i[7]) begin
						// Foreign response frame: skip data and check bytes
						skip_cnt <= {1'b0, rx_byte_i[6:0]} + 8'h03;
						rx_state <= R_SKIP;
					end else if (rx_byte_i[6:5] == dcfc_pkg::KIND_BCAST) begin
						rx_state <= rx_byte_i[3] ? R_REGHI : R_REGLO;
					end else begin
						rx_state <= R_ID;
					end
				end
				R_ID: begin
					target_id <= rx_byte_i;
					rx_state <= hdr.wide_addr ? R_REGHI : R_REGLO;
				end
				R_REGHI: begin
					reg_addr[15:8] <= rx_byte_i;
					rx_state <= R_REGLO;
				end
				R_REGLO: begin
					reg_addr[7:0] <= rx_byte_i;
					data_idx <= 4'h0;
					rx_state <= (data_len == 4'h0) ? R_CRC1 : R_DATA;
				end
				R_DATA: begin
					data_idx <= data_idx + 4'h1;
					if (data_idx == data_len - 4'h1) begin
						rx_state <= R_CRC1;
					end
				end
				R_CRC1: rx_state <= R_CRC2;
				R_CRC2: rx_state <= R_INIT;
				R_SKIP: begin
					skip_cnt <= skip_cnt - 8'h01;
					if (skip_cnt == 8'h01) begin
						rx_state <= R_INIT;
					end
				end
			endcase
		end
	end

	// Data payload capture
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 8; i++) begin
				data_buf[i] <= 8'h00;
			end
		end else if (rx_valid_i && rx_state == R_DATA) begin
			data_buf[data_idx[2:0]] <= rx_byte_i;
		end
	end

	// Running check over every received byte
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_crc <= dcfc_pkg::CRC_INIT;
		end else if (rx_valid_i) begin
			rx_crc <= next_rx_crc;
		end
	end

	// Frame acceptance decision
	always_comb begin
		frame_done = rx_valid_i && rx_state == R_CRC2;
		frame_good = next_rx_crc == dcfc_pkg::CRC_INIT;
		unique case (hdr.target_kind)
			dcfc_pkg::KIND_SINGLE: target_hit = target_id == mem[dcfc_pkg::REG_NODE_ID[AW-1:0]];
			dcfc_pkg::KIND_GROUP: target_hit = target_id == mem[dcfc_pkg::REG_GROUP_MATCH_IDENTIFIER[AW-1:0]];
			dcfc_pkg::KIND_BCAST: target_hit = 1'b1;
			default: target_hit = 1'b0;
		endcase
		accept = frame_done && frame_good && target_hit;
		is_sample = reg_addr == {8'h00, dcfc_pkg::REG_SAMPLE_CMD};
	end

	// Status pulses
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			frame_ok_o <= 1'b0;
			crc_err_o <= 1'b0;
			sample_start_o <= 1'b0;
		end else begin
			frame_ok_o <= accept;
			crc_err_o <= frame_done && !frame_good;
			sample_start_o <= accept && is_sample;
		end
	end

	// Sequential register store; sampling frames skip the responder byte
	always_comb begin
		if (is_sample && wr_idx == 4'h0) begin
			// First sampling byte lands in the command register itself
			wr_addr = {8'h00, dcfc_pkg::REG_SAMPLE_CMD};
		end else if (is_sample) begin
			wr_addr = {12'h000, wr_idx} + 16'h0001;
		end else begin
			wr_addr = reg_addr + {12'h000, wr_idx};
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_busy <= 1'b0;
			wr_idx <= 4'h0;
		end else if (accept && data_len != 4'h0 &&
			(hdr.no_reply || is_sample)) begin
			wr_busy <= 1'b1;
			wr_idx <= 4'h0;
		end else if (wr_busy) begin
			wr_idx <= wr_idx + 4'h1;
			if (wr_idx == data_len - 4'h1) begin
				wr_busy <= 1'b0;
			end
		end
	end

	// Register array; out-of-range writes are dropped
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < NREG; i++) begin
				mem[i] <= 8'h00;
			end
			mem[dcfc_pkg::REG_NODE_ID[AW-1:0]] <= NODE_ID_INIT;
			mem[dcfc_pkg::REG_GROUP_MATCH_IDENTIFIER[AW-1:0]] <= GROUP_MATCH_IDENTIFIER_INIT;
		end else if (wr_busy && wr_addr < 16'(NREG)) begin
			if (!(is_sample && wr_idx == 4'h1)) begin
				mem[wr_addr[AW-1:0]] <= data_buf[wr_idx[2:0]];
			end
		end
	end

	// Highest responder byte of a sampling frame
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			highest_node <= 8'h00;
		end else if (wr_busy && is_sample && wr_idx == 4'h1) begin
			highest_node <= data_buf[1];
		end
	end

	always_comb begin
		sample_cfg_o.sample_cmd = mem[dcfc_pkg::REG_SAMPLE_CMD[AW-1:0]];
		sample_cfg_o.highest_node = highest_node;
		sample_cfg_o.oversample = mem[dcfc_pkg::REG_OVERSAMPLE[AW-1:0]];
		sample_cfg_o.chan_select = {mem[dcfc_pkg::REG_CHAN_SEL[AW-1:0]],
			mem[dcfc_pkg::REG_CHAN_SEL[AW-1:0] + AW'(1)],
			mem[dcfc_pkg::REG_CHAN_SEL[AW-1:0] + AW'(2)],
			mem[dcfc_pkg::REG_CHAN_SEL[AW-1:0] + AW'(3)]};
		node_id_o = mem[dcfc_pkg::REG_NODE_ID[AW-1:0]];
		group_match_identifier_o = mem[dcfc_pkg::REG_GROUP_MATCH_IDENTIFIER[AW-1:0]];
	end

	// Read-back byte source for the reply
	always_comb begin
		rd_addr = rd_base + {9'h000, rd_idx};
		rd_byte = (rd_addr < 16'(NREG)) ? mem[rd_addr[AW-1:0]] : 8'h00;
		next_tx_crc = crc_byte(tx_crc, tx_byte_o);
		tx_valid_o = tx_state != T_IDLE;
	end

	// Reply sender, started only by an accepted command
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_state <= T_IDLE;
			tx_byte_o <= 8'h00;
			tx_crc <= dcfc_pkg::CRC_INIT;
			rd_base <= 16'h0000;
			rd_last <= 7'h00;
			rd_idx <= 7'h00;
		end else begin
			unique case (tx_state)
				T_IDLE: begin
					if (accept && !hdr.no_reply) begin
						rd_base <= reg_addr;
						rd_idx <= 7'h00;
						tx_crc <= dcfc_pkg::CRC_INIT;
						if (is_sample || data_len == 4'h0) begin
							rd_last <= 7'h00;
							tx_byte_o <= 8'h00;
						end else begin
							rd_last <= data_buf[0][6:0];
							tx_byte_o <= {1'b0, data_buf[0][6:0]};
						end
						tx_state <= T_INIT;
					end
				end
				T_INIT: begin
					if (tx_ready_i) begin
						tx_crc <= next_tx_crc;
						tx_byte_o <= rd_byte;
						tx_state <= T_DATA;
					end
				end
				T_DATA: begin
					if (tx_ready_i) begin
						tx_crc <= next_tx_crc;
						if (rd_idx == rd_last) begin
							tx_byte_o <= next_tx_crc[7:0];
							tx_state <= T_CRC1;
						end else begin
							rd_idx <= rd_idx + 7'h01;
							tx_byte_o <= rd_addr < 16'(NREG) - 16'h0001 ?
								mem[rd_addr[AW-1:0] + AW'(1)] : 8'h00;
						end
					end
				end
				T_CRC1: begin
					if (tx_ready_i) begin
						tx_byte_o <= tx_crc[15:8];
						tx_state <= T_CRC2;
					end
				end
				T_CRC2: begin
					if (tx_ready_i) begin
						tx_state <= T_IDLE;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* sim/dcfc_codec_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module dcfc_codec_monitor (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] tx_byte_o,
	input wire logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire dcfc_pkg::dcfc_sample_cfg_t sample_cfg_o,
	input wire logic sample_start_o,
	input wire logic frame_ok_o,
	input wire logic crc_err_o,
	input wire logic [7:0] node_id_o,
	input wire logic [7:0] group_match_identifier_o
);
	// One clock domain, checks idle in reset
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Cycles since the last accepted frame, saturating
	logic [3:0] since_ok;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			since_ok <= 4'hf;
		end else if (frame_ok_o) begin
			since_ok <= 4'h0;
		end else if (since_ok != 4'hf) begin
			since_ok <= since_ok + 4'h1;
		end
	end
	a_tx_held: assert property (
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o)
	) else $error("reply byte moved");
	a_ok_excl: assert property (!(frame_ok_o && crc_err_o))
		else $error("ok with crc error");
	a_ok_pulse: assert property (frame_ok_o |=> !frame_ok_o)
		else $error("ok not a pulse");
	a_bad_no_write: assert property (
		crc_err_o |=> $stable(node_id_o) && $stable(sample_cfg_o) && !tx_valid_o
	) else $error("bad frame acted on");
	a_id_after_ok: assert property (
		$changed(node_id_o) || $changed(group_match_identifier_o) |-> $past(frame_ok_o)
	) else $error("id changed without frame");
	a_cfg_after_ok: assert property (
		$changed(sample_cfg_o) |-> since_ok <= 4'h7
	) else $error("config changed without frame");
	a_start_after_ok: assert property (
		sample_start_o |-> frame_ok_o || $past(frame_ok_o) || $past(frame_ok_o, 2)
	) else $error("start without frame");
	a_reply_cmd: assert property (
		$rose(tx_valid_o) |-> frame_ok_o || $past(frame_ok_o)
	) else $error("reply without command");
	a_reply_kind: assert property ($rose(tx_valid_o) |-> !tx_byte_o[7])
		else $error("reply kind bit set");
	c_ok: cover property (frame_ok_o);
	c_err: cover property (crc_err_o);
	c_stall: cover property (tx_valid_o && !tx_ready_i ##1 tx_ready_i);
endmodule
bind dcfc_codec dcfc_codec_monitor i_mon (.ref_clk_i, .sys_rst_i, .tx_byte_o,
	.tx_valid_o, .tx_ready_i, .sample_cfg_o, .sample_start_o, .frame_ok_o,
	.crc_err_o, .node_id_o, .group_match_identifier_o);
`default_nettype wire

/* sim/dcfc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcfc_host_model (
	input wire logic ref_clk_i,
	output logic [7:0] rx_byte_o,
	output logic rx_valid_o,
	input wire logic [7:0] tx_byte_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o
);
	// Idle link at time zero
	initial begin
		rx_byte_o = 8'h00;
		rx_valid_o = 1'b0;
		tx_ready_o = 1'b0;
	end
	// Reflected check step, bytes taken LSB first
	function automatic logic [15:0] crc_step(input logic [15:0] c,
		input logic [7:0] b);
		c = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		return c;
	endfunction
	// Sends a whole frame back to back, low check byte first
	task automatic send(input logic [7:0] f[$], input logic bad);
		logic [15:0] c;
		c = 16'h0000;
		foreach (f[i])
			c = crc_step(c, f[i]);
		f.push_back(c[7:0] ^ {7'h00, bad});
		f.push_back(c[15:8]);
		foreach (f[i]) begin
			@(posedge ref_clk_i);
			#1;
			rx_byte_o = f[i];
			rx_valid_o = 1'b1;
		end
		@(posedge ref_clk_i);
		#1;
		rx_valid_o = 1'b0;
		rx_byte_o = ~rx_byte_o;
	endtask
	// Takes one reply byte after a stall cycle
	task automatic get(output logic [7:0] b);
		logic ok;
		@(posedge ref_clk_i);
		#1;
		tx_ready_o = 1'b1;
		ok = 1'b0;
		b = 8'h00;
		repeat (50) begin
			// Settled values are the ones taken at the coming edge
			ok = tx_valid_i === 1'b1;
			b = tx_byte_i;
			@(posedge ref_clk_i);
			if (ok)
				break;
			#1;
		end
		#1;
		tx_ready_o = 1'b0;
	endtask
endmodule
`default_nettype wire

/* sim/dcfc_codec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dcfc_codec_tb;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] rx_byte_i, tx_byte_o, node_id_o, group_match_identifier_o, prev;
	logic rx_valid_i, tx_valid_o, tx_ready_i, sample_start_o, frame_ok_o, crc_err_o;
	dcfc_pkg::dcfc_sample_cfg_t sample_cfg_o;
	logic [7:0] f[$];
	int n_mismatch = 0, num_checks = 0, n_ok = 0, n_err = 0, n_go = 0, cyc = 0;
	int cnt;
	logic [15:0] vec;
	always #4 ref_clk_i = ~ref_clk_i;
	dcfc_codec i_dut (.ref_clk_i, .sys_rst_i, .rx_byte_i, .rx_valid_i,
		.tx_byte_o, .tx_valid_o, .tx_ready_i, .sample_cfg_o, .sample_start_o,
		.frame_ok_o, .crc_err_o, .node_id_o, .group_match_identifier_o);
	dcfc_host_model i_host (.ref_clk_i, .rx_byte_o(rx_byte_i),
		.rx_valid_o(rx_valid_i), .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o),
		.tx_ready_o(tx_ready_i));
	// Pulse counters and hang guard
	always @(posedge ref_clk_i) begin
		n_ok += (frame_ok_o === 1'b1);
		n_err += (crc_err_o === 1'b1);
		n_go += (sample_start_o === 1'b1);
		cyc++;
		if (cyc > 5000) begin
			n_mismatch++;
			finish_test;
		end
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] q[$], input logic bad = 1'b0);
		i_host.send(q, bad);
		repeat (10) @(posedge ref_clk_i);
		#1;
	endtask
	// Collects a reply and checks its residue is zero
	task automatic reply(input logic [7:0] e[$]);
		logic [7:0] b;
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 0; i < e.size() + 2; i++) begin
			i_host.get(b);
			c = i_host.crc_step(c, b);
			if (i < e.size())
				chk(b, e[i], "reply byte");
		end
		chk(c, 32'h0, "reply check");
	endtask
	initial begin
		repeat (3) @(posedge ref_clk_i);
		#1;
		sys_rst_i = 1'b0;
		chk(node_id_o, 8'h00, "node reset");
		chk(group_match_identifier_o, 8'h00, "group reset");
		wr('{8'hf1, 8'h0a, 8'h03});
		wr('{8'hf1, 8'h0b, 8'h05});
		chk(node_id_o, 8'h03, "node write");
		chk(group_match_identifier_o, 8'h05, "group write");
		// Every request kind code aimed at register 7
		for (int k = 0; k < 8; k++) begin
			prev = sample_cfg_o.oversample;
			cnt = n_ok;
			f = '{{1'b1, k[2:0], 4'h1}};
			if (k < 6)
				f.push_back(k[1] ? 8'h05 : 8'h03);
			f.push_back(8'h07);
			f.push_back(k[0] ? 8'h10 + k[7:0] : 8'h00);
			wr(f);
			if (k == 4 || k == 5) begin
				chk(sample_cfg_o.oversample, prev, "reserved wrote");
				chk(n_ok, cnt, "reserved accepted");
			end else if (k[0])
				chk(sample_cfg_o.oversample, 8'h10 + k[7:0], "kind write");
			else
				reply('{8'h00, prev});
			chk(tx_valid_o, 1'b0, "stray reply");
		end
		wr('{8'h91, 8'h09, 8'h07, 8'h21});
		chk(sample_cfg_o.oversample, 8'h17, "unmatched wrote");
		cnt = n_err;
		wr('{8'h91, 8'h03, 8'h07, 8'h22}, 1'b1);
		chk(sample_cfg_o.oversample, 8'h17, "bad crc wrote");
		chk(n_err, cnt + 1, "crc error pulse");
		// Known check value of a short command frame
		vec = i_host.crc_step(16'h0000, 8'h91);
		vec = i_host.crc_step(vec, 8'h03);
		vec = i_host.crc_step(vec, 8'h07);
		vec = i_host.crc_step(vec, 8'h05);
		chk(vec, 32'hcf1e, "crc vector");
		// Foreign response frame is skipped whole
		cnt = n_ok;
		wr('{8'h01, 8'haa, 8'hbb});
		wr('{8'h91, 8'h03, 8'h07, 8'h33});
		chk(sample_cfg_o.oversample, 8'h33, "after response frame");
		chk(n_ok, cnt + 1, "response frame skipped");
		wr('{8'h91, 8'h03, 8'h07, 8'h05});
		chk(sample_cfg_o.oversample, 8'h05, "sample frame");
		wr('{8'h99, 8'h03, 8'h00, 8'h07, 8'h0c});
		chk(sample_cfg_o.oversample, 8'h0c, "wide address");
		cnt = n_go;
		wr('{8'h94, 8'h03, 8'h02, 8'h11, 8'h07, 8'ha1, 8'ha2});
		chk(sample_cfg_o.sample_cmd, 8'h11, "sample command");
		chk(sample_cfg_o.highest_node, 8'h07, "highest node");
		chk(sample_cfg_o.chan_select[31:16], 16'ha1a2, "channels");
		chk(n_go, cnt + 1, "start pulse");
		f = '{8'hf7, 8'h03, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'h0e, 8'h00, 8'h00, 8'h03};
		wr(f);
		chk(sample_cfg_o.chan_select, 32'hc1c2c3c4, "eight bytes");
		chk(sample_cfg_o.oversample, 8'h0e, "eight bytes avg");
		wr('{8'he1, 8'h0a, 8'h01});
		reply('{8'h01, 8'h03, 8'h05});
		finish_test;
	end
endmodule
`default_nettype wire
